//--- src/rsq_seq.sv
// reset and interrupt sequencer for the processor core
//
// Function
// - five reset sources: power-on, pin low, low voltage, illegal fetch, watchdog
// - every reset vectors to 3FFE/3FFF and sets the interrupt mask
// - after power-on delay, stay in reset while the reset pin is low
// - resume execution two cycles after the reset pin returns high, once the low-time filter has cleared
// - reset pin is bidirectional, driven low by the low voltage reset
// - opcode fetch outside RAM, EEPROM or program memory resets the device
// - watchdog reset keeps the operating mode, mode is not resampled
// - watchdog reset presence is a build-time parameter
// - pull pin low while supply is low, release when it recovers
// - five maskable hardware sources plus the software interrupt instruction
// - on interrupt entry stack registers first, then set the mask
// - return from interrupt restores the stacked mask state
// - requests wait for instruction end, need mask clear and enable set
// - power-on or pin reset clears all interrupt enables
// - highest priority pending interrupt is serviced first
// - software interrupt is taken regardless of the mask
// - requests pending at software interrupt fetch go first, later ones after
// - software interrupt vectors through 3FFC/3FFD
// - mask set blocks all maskable sources; clearing it lets them run
// - pin and keyboard share 3FFA, core timer 3FF8, 16-bit timer 3FF6
// - low voltage interrupt vectors through 3FF4
`timescale 1ns/10ps
`default_nettype none

module rsq_seq
    import rsq_pkg::*;
#(
    parameter bit WATCHDOG_PRESENT = 1'b1,
    parameter int POR_CYCLES = POR_DELAY_CYCLES,
    parameter int PIN_CYCLES = PIN_LOW_CYCLES,
    parameter logic [13:0] PROG_LO = PROG_LO_DEF,
    parameter logic [13:0] PROG_HI = PROG_HI_DEF
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic osc_stable_i,
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    input wire logic low_voltage_i,
    input wire logic watchdog_timeout_i,
    input wire logic mode_sel_i,
    input wire logic fetch_valid_i,
    input wire logic [13:0] fetch_addr_i,
    input wire logic [4:0] irq_req_i,
    input wire logic en_write_i,
    input wire logic [4:0] en_wdata_i,
    input wire logic instr_done_i,
    input wire logic swi_fetch_i,
    input wire logic swi_exec_i,
    input wire logic stack_done_i,
    input wire logic rti_i,
    input wire logic rti_mask_i,
    input wire logic mask_set_i,
    input wire logic mask_clear_i,
    output logic core_reset_o,
    output logic push_req_o,
    output logic vector_valid_o,
    output logic [13:0] vector_addr_o,
    output logic int_mask_o,
    output logic [4:0] int_enable_o,
    output logic [2:0] reset_cause_o,
    output logic op_mode_o
);
    typedef enum logic [1:0] {
        ST_POR,
        ST_HOLD,
        ST_RUN,
        ST_STACK
    } rsq_state_e;

    rsq_state_e state_reg;
    rsq_cause_e cause_reg;
    logic por_done;
    logic [7:0] pin_low_cnt_reg;
    logic pin_reset;
    logic illegal_fetch;
    logic wdog_reset;
    logic run_reset;
    logic [4:0] pending;
    logic [4:0] snap_reg;
    logic swi_pend_reg;
    logic [4:0] hw_pool;
    logic take_swi;
    logic take_hw;
    logic [13:0] entry_vec_reg;
    logic mask_reg;
    logic [4:0] en_reg;
    logic mode_reg;
    logic vec_valid_reg;
    logic [13:0] vec_addr_reg;

    // fetch legality across the three memory windows
    function automatic logic addr_legal(input logic [13:0] a);
        addr_legal = (a >= RAM_LO && a <= RAM_HI) || (a >= EE_LO && a <= EE_HI)
            || (a >= PROG_LO && a <= PROG_HI);
    endfunction : addr_legal

    // fixed priority pick, lowest index wins
    function automatic logic [13:0] pick_vector(input logic [4:0] p);
        if (p[SRC_EXT] || p[SRC_KEY]) begin
            pick_vector = VEC_EXT_KEY;
        end else if (p[SRC_CTMR]) begin
            pick_vector = VEC_CORE_TMR;
        end else if (p[SRC_TMR16]) begin
            pick_vector = VEC_TMR16;
        end else begin
            pick_vector = VEC_LVI;
        end
    endfunction : pick_vector

    ////////////////////////////////////////////////////////////////////////////
    rsq_por_timer #(
        .DELAY_CYCLES(POR_CYCLES)
    ) u_por (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .osc_stable_i(osc_stable_i),
        .done_o(por_done)
    );

    // low-time filter on the pin: short glitches do not reset
    always_ff @(posedge clk_i) begin
        if (srst_i || reset_pin_i) begin
            pin_low_cnt_reg <= 8'h00;
        end else if (pin_low_cnt_reg < 8'(PIN_CYCLES)) begin
            pin_low_cnt_reg <= pin_low_cnt_reg + 8'h01;
        end
    end

    assign pin_reset = (pin_low_cnt_reg >= 8'(PIN_CYCLES)) || low_voltage_i;
    assign illegal_fetch = fetch_valid_i && !addr_legal(fetch_addr_i);
    assign wdog_reset = WATCHDOG_PRESENT && watchdog_timeout_i;
    assign run_reset = pin_reset || illegal_fetch || wdog_reset;

    // open-drain style drive: low only while supply is low
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe_o = low_voltage_i;

    ////////////////////////////////////////////////////////////////////////////
    // software interrupt and hardware arbitration at instruction boundaries
    assign pending = irq_req_i & en_reg;
    // while a software interrupt waits, only requests seen at its fetch may go first
    assign hw_pool = swi_pend_reg ? (snap_reg & pending) : pending;
    assign take_hw = (state_reg == ST_RUN) && instr_done_i && !mask_reg
        && (hw_pool != 5'h00);
    assign take_swi = (state_reg == ST_RUN) && instr_done_i && swi_pend_reg
        && !take_hw;

    // snapshot of pending requests at the software interrupt fetch
    always_ff @(posedge clk_i) begin
        if (srst_i || state_reg == ST_POR || state_reg == ST_HOLD) begin
            swi_pend_reg <= 1'b0;
            snap_reg <= 5'h00;
        end else if (swi_fetch_i) begin
            swi_pend_reg <= 1'b1;
            snap_reg <= pending;
        end else if (take_swi) begin
            swi_pend_reg <= 1'b0;
            snap_reg <= 5'h00; // a stale snapshot must not outrank a later request
        end else if (swi_exec_i && !swi_pend_reg) begin
            swi_pend_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence: reset hold, run, interrupt stacking
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= ST_POR;
            cause_reg <= CAUSE_POR;
            entry_vec_reg <= VEC_RESET;
        end else begin
            case (state_reg)
                ST_POR: begin
                    if (por_done) begin
                        // pin still low at end of delay keeps us in reset
                        state_reg <= pin_reset ? ST_HOLD : ST_RUN;
                        if (pin_reset) begin
                            cause_reg <= low_voltage_i ? CAUSE_LVR : CAUSE_PIN;
                        end
                    end
                end
                ST_HOLD: begin
                    if (!pin_reset && reset_pin_i) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN, ST_STACK: begin
                    if (run_reset) begin
                        state_reg <= ST_HOLD;
                        if (low_voltage_i) begin
                            cause_reg <= CAUSE_LVR;
                        end else if (pin_reset) begin
                            cause_reg <= CAUSE_PIN;
                        end else if (illegal_fetch) begin
                            cause_reg <= CAUSE_ILLEGAL;
                        end else begin
                            cause_reg <= CAUSE_WDOG;
                        end
                    end else if (state_reg == ST_RUN && take_hw) begin
                        state_reg <= ST_STACK;
                        entry_vec_reg <= pick_vector(hw_pool);
                    end else if (state_reg == ST_RUN && take_swi) begin
                        state_reg <= ST_STACK;
                        entry_vec_reg <= VEC_SWI;
                    end else if (state_reg == ST_STACK && stack_done_i) begin
                        state_reg <= ST_RUN;
                    end
                end
                default: begin
                    state_reg <= ST_POR;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt mask: reset sets it, stacking sets it after the push, return restores
    always_ff @(posedge clk_i) begin
        if (srst_i || state_reg == ST_POR || state_reg == ST_HOLD) begin
            mask_reg <= 1'b1;
        end else if (run_reset) begin
            mask_reg <= 1'b1;
        end else if (state_reg == ST_STACK && stack_done_i) begin
            mask_reg <= 1'b1;
        end else if (rti_i) begin
            mask_reg <= rti_mask_i;
        end else if (mask_set_i) begin
            mask_reg <= 1'b1;
        end else if (mask_clear_i) begin
            mask_reg <= 1'b0;
        end
    end

    // interrupt enables; illegal fetch and watchdog leave them untouched
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            en_reg <= EN_RESET;
        end else if (state_reg == ST_POR || (state_reg == ST_HOLD && cause_reg != CAUSE_ILLEGAL
                && cause_reg != CAUSE_WDOG)) begin
            en_reg <= EN_RESET;
        end else if (en_write_i && state_reg != ST_HOLD) begin
            en_reg <= en_wdata_i;
        end
    end

    // operating mode sampled only by power-on, pin and low voltage resets
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode_reg <= 1'b0;
        end else if (state_reg == ST_POR || (state_reg == ST_HOLD && cause_reg != CAUSE_WDOG
                && cause_reg != CAUSE_ILLEGAL)) begin
            mode_reg <= mode_sel_i;
        end
    end

    // vector handed to the fetch logic: on reset exit and after stacking
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            vec_valid_reg <= 1'b0;
            vec_addr_reg <= VEC_RESET;
        end else if ((state_reg == ST_HOLD && !pin_reset && reset_pin_i)
                || (state_reg == ST_POR && por_done && !pin_reset)) begin
            vec_valid_reg <= 1'b1;
            vec_addr_reg <= VEC_RESET;
        end else if (state_reg == ST_STACK && stack_done_i && !run_reset) begin
            vec_valid_reg <= 1'b1;
            vec_addr_reg <= entry_vec_reg;
        end else begin
            vec_valid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign core_reset_o = (state_reg == ST_POR) || (state_reg == ST_HOLD);
    assign push_req_o = (state_reg == ST_STACK);
    assign vector_valid_o = vec_valid_reg;
    assign vector_addr_o = vec_addr_reg;
    assign int_mask_o = mask_reg;
    assign int_enable_o = en_reg;
    assign reset_cause_o = cause_reg;
    assign op_mode_o = mode_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_reset_vector: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_HOLD && !pin_reset && reset_pin_i) |=> vector_valid_o
        && vector_addr_o == 14'h3FFE && int_mask_o)
        else $error("reset exit did not vector to 3FFE with mask set");
    a_illegal_fetch: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_RUN && fetch_valid_i && fetch_addr_i == 14'h0140) |=> core_reset_o)
        else $error("fetch from 0140 did not reset");
    a_resume_next: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_HOLD && !pin_reset && reset_pin_i) |=> !core_reset_o)
        else $error("no resume on cycle after pin release");
    a_lvr_drive: assert property (@(posedge clk_i)
        low_voltage_i |-> (reset_pin_oe_o && !reset_pin_o))
        else $error("reset pin not pulled low under low voltage");
    a_wdog_mode: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_HOLD && cause_reg == CAUSE_WDOG) |=> $stable(op_mode_o))
        else $error("mode changed during watchdog reset");
    a_mask_blocks: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_RUN && mask_reg && !swi_pend_reg && !run_reset) |=> state_reg != ST_STACK)
        else $error("maskable interrupt taken with mask set");
    a_swi_nomask: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_RUN && instr_done_i && swi_pend_reg && mask_reg && !run_reset)
        |=> state_reg == ST_STACK ##0 entry_vec_reg == 14'h3FFC)
        else $error("software interrupt not taken under mask");
    a_priority: assert property (@(posedge clk_i) disable iff (srst_i)
        (take_hw && hw_pool[SRC_EXT] && hw_pool[SRC_TMR16] && !run_reset)
        |=> entry_vec_reg == 14'h3FFA)
        else $error("external interrupt lost to timer");
    a_stack_then_mask: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_STACK && stack_done_i && !run_reset) |=> int_mask_o
        && vector_valid_o && !push_req_o)
        else $error("mask not set after stacking");
    a_enable_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_HOLD && cause_reg == CAUSE_PIN) |=> int_enable_o == 5'h00)
        else $error("enables survived pin reset");
    // stacking handshake, vectors, return, enables kept on illegal fetch, mask held in reset and pin release
    a_push_hold: assert property (@(posedge clk_i) disable iff (srst_i)
        (push_req_o && !stack_done_i && !run_reset) |=> push_req_o)
        else $error("push request dropped before stacking finished");
    a_core_timer_vec: assert property (@(posedge clk_i) disable iff (srst_i)
        (take_hw && hw_pool[2:0] == 3'b100 && !run_reset) |=> entry_vec_reg == 14'h3FF8)
        else $error("core timer did not vector to 3FF8");
    a_lvi_vec: assert property (@(posedge clk_i) disable iff (srst_i)
        (take_hw && hw_pool == 5'h10 && !run_reset) |=> entry_vec_reg == 14'h3FF4)
        else $error("low voltage interrupt did not vector to 3FF4");
    a_rti_restore: assert property (@(posedge clk_i) disable iff (srst_i)
        (rti_i && state_reg == ST_RUN && !run_reset) |=> int_mask_o == $past(rti_mask_i))
        else $error("return did not restore the stacked mask");
    a_enable_keep: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == ST_HOLD && cause_reg == CAUSE_ILLEGAL) |=> $stable(int_enable_o))
        else $error("illegal fetch reset changed the enables");
    a_reset_masked: assert property (@(posedge clk_i) disable iff (srst_i)
        core_reset_o |-> int_mask_o)
        else $error("mask clear while in reset");
    a_pin_release: assert property (@(posedge clk_i)
        !low_voltage_i |-> !reset_pin_oe_o)
        else $error("reset pin driven with supply good");
endmodule : rsq_seq

`default_nettype wire

//--- src/rsq_pkg.sv
// package and power-up stabilisation timer for the reset and interrupt sequencer
`timescale 1ns/10ps
`default_nettype none

package rsq_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int MACHINE_CYCLE_NS = 100;
    // pin must be low 1.5 machine cycles, i.e. 3/2 of a cycle, rounded up
    localparam int PIN_LOW_NS_X2 = 3 * MACHINE_CYCLE_NS;
    localparam int PIN_LOW_CYCLES = (PIN_LOW_NS_X2 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    localparam int POR_DELAY_CYCLES = 4096;
    localparam int ADDR_W = 14;
    // vector addresses (high byte of each pair)
    localparam logic [13:0] VEC_RESET = 14'h3FFE;
    localparam logic [13:0] VEC_SWI = 14'h3FFC;
    localparam logic [13:0] VEC_EXT_KEY = 14'h3FFA;
    localparam logic [13:0] VEC_CORE_TMR = 14'h3FF8;
    localparam logic [13:0] VEC_TMR16 = 14'h3FF6;
    localparam logic [13:0] VEC_LVI = 14'h3FF4;
    // legal fetch ranges
    localparam logic [13:0] RAM_LO = 14'h0040;
    localparam logic [13:0] RAM_HI = 14'h013F;
    localparam logic [13:0] EE_LO = 14'h0200;
    localparam logic [13:0] EE_HI = 14'h02FF;
    localparam logic [13:0] PROG_LO_DEF = 14'h1000;
    localparam logic [13:0] PROG_HI_DEF = 14'h3FFF;
    // interrupt source bit positions, highest priority at the lowest index
    localparam int SRC_EXT = 0;
    localparam int SRC_KEY = 1;
    localparam int SRC_CTMR = 2;
    localparam int SRC_TMR16 = 3;
    localparam int SRC_LVI = 4;
    localparam int NUM_SRC = 5;
    localparam logic [4:0] EN_RESET = 5'h00;

    typedef enum logic [2:0] {
        CAUSE_POR,
        CAUSE_PIN,
        CAUSE_LVR,
        CAUSE_ILLEGAL,
        CAUSE_WDOG
    } rsq_cause_e;
endpackage : rsq_pkg

////////////////////////////////////////////////////////////////////////////////
// counts stable oscillator cycles after power-on, flags the end of the delay
module rsq_por_timer
    import rsq_pkg::*;
#(
    parameter int DELAY_CYCLES = POR_DELAY_CYCLES
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic osc_stable_i,
    output logic done_o
);
    logic [15:0] count_reg;

    // count only while the oscillator is stable; stop at the end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count_reg <= 16'h0000;
        end else if (osc_stable_i && !done_o) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    assign done_o = (count_reg >= 16'(DELAY_CYCLES));
endmodule : rsq_por_timer

`default_nettype wire

//--- tb/rsq_core_model.sv
// behavioural model of the core's stacking logic facing the sequencer
`timescale 1ns/10ps
`default_nettype none

module rsq_core_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic push_req_i,
    input wire logic [2:0] stall_i,
    output logic stack_done_o
);
    logic [2:0] wait_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // registers are pushed for stall_i + 1 cycles, then one done pulse per request
    // done drops on its own so a slow release of push_req is never double counted
    always_ff @(posedge clk_i) begin
        if (srst_i || !push_req_i || stack_done_o) begin
            wait_reg <= 3'h0;
            stack_done_o <= 1'b0;
        end else if (wait_reg == stall_i) begin
            stack_done_o <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 3'h1;
        end
    end
endmodule : rsq_core_model

`default_nettype wire

//--- tb/reset_and_interrupt_sequencer_tb.sv
// self-checking bench for the reset and interrupt sequencer
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module reset_and_interrupt_sequencer_tb;
    import rsq_pkg::*;
    logic clk_i, srst_i, osc_stable_i, ext_pin, pin_w, reset_pin_o, reset_pin_oe_o;
    logic low_voltage_i, watchdog_timeout_i, mode_sel_i, fetch_valid_i;
    logic [13:0] fetch_addr_i, vector_addr_o;
    logic [4:0] irq_req_i, en_wdata_i, int_enable_o, exp_en;
    logic en_write_i, instr_done_i, swi_fetch_i, stack_done_i, rti_i, rti_mask_i, swi_exec;
    logic mask_set_i, mask_clear_i, core_reset_o, push_req_o, vector_valid_o;
    logic int_mask_o, op_mode_o;
    logic [2:0] reset_cause_o, stall;
    int errors, comparisons, idx, r;
    logic [13:0] bad_q[$] = '{14'h003F, 14'h0140, 14'h01FF, 14'h0300, 14'h0FFF};
    logic [13:0] good_q[$] = '{14'h0040, 14'h013F, 14'h0200, 14'h02FF, 14'h1000, 14'h3FFF};

    // pin level: the sequencer's low drive wins over the outside party
    assign pin_w = reset_pin_oe_o ? reset_pin_o : ext_pin;

    rsq_seq #(.POR_CYCLES(8)) dut_u (.clk_i(clk_i), .srst_i(srst_i),
        .osc_stable_i(osc_stable_i), .reset_pin_i(pin_w), .reset_pin_o(reset_pin_o),
        .reset_pin_oe_o(reset_pin_oe_o), .low_voltage_i(low_voltage_i),
        .watchdog_timeout_i(watchdog_timeout_i), .mode_sel_i(mode_sel_i),
        .fetch_valid_i(fetch_valid_i), .fetch_addr_i(fetch_addr_i), .irq_req_i(irq_req_i),
        .en_write_i(en_write_i), .en_wdata_i(en_wdata_i), .instr_done_i(instr_done_i),
        .swi_fetch_i(swi_fetch_i), .swi_exec_i(swi_exec), .stack_done_i(stack_done_i),
        .rti_i(rti_i), .rti_mask_i(rti_mask_i), .mask_set_i(mask_set_i),
        .mask_clear_i(mask_clear_i), .core_reset_o(core_reset_o), .push_req_o(push_req_o),
        .vector_valid_o(vector_valid_o), .vector_addr_o(vector_addr_o),
        .int_mask_o(int_mask_o), .int_enable_o(int_enable_o),
        .reset_cause_o(reset_cause_o), .op_mode_o(op_mode_o));

    rsq_core_model core_u (.clk_i(clk_i), .srst_i(srst_i), .push_req_i(push_req_o),
        .stall_i(stall), .stack_done_o(stack_done_i));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        #1000000;
        errors++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared stimulus tasks, entered and left at a falling edge
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
    endtask : pulse

    function automatic logic [13:0] vec_of(input int i);
        case (i)
            0, 1: return 14'h3FFA;
            2: return 14'h3FF8;
            3: return 14'h3FF6;
            default: return 14'h3FF4;
        endcase
    endfunction : vec_of

    task automatic wait_vec(input logic [13:0] e);
        int n;
        n = 0;
        while (vector_valid_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        `CHK("vector valid", 1'b1, vector_valid_o)
        `CHK("vector", e, vector_addr_o)
        `CHK("mask", 1'b1, int_mask_o)
        `CHK("core_reset", 1'b0, core_reset_o)
        @(negedge clk_i);
    endtask : wait_vec

    // instruction boundary, then the stacking handshake and the vector
    task automatic take(input logic [13:0] e);
        stall = 3'($urandom_range(0, 5));
        pulse(instr_done_i);
        `CHK("push_req", 1'b1, push_req_o)
        wait_vec(e);
    endtask : take

    task automatic do_rti(input logic m);
        rti_mask_i = m;
        pulse(rti_i);
        `CHK("rti mask", m, int_mask_o)
    endtask : do_rti

    task automatic check_reset(input logic [2:0] c, input logic [4:0] en, input logic md);
        wait_vec(14'h3FFE);
        `CHK("cause", c, reset_cause_o)
        `CHK("enables", en, int_enable_o)
        `CHK("mode", md, op_mode_o)
    endtask : check_reset

    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {srst_i, osc_stable_i, ext_pin, low_voltage_i, watchdog_timeout_i} = 5'h10;
        {fetch_valid_i, en_write_i, instr_done_i, swi_fetch_i, rti_i} = 5'h00;
        swi_exec = 1'b0;
        {rti_mask_i, mask_set_i, mask_clear_i, mode_sel_i} = 4'h1;
        fetch_addr_i = 14'h1000;
        irq_req_i = 5'h00;
        en_wdata_i = 5'h00;
        stall = 3'h0;
        void'($urandom(90079));
        repeat (8) @(negedge clk_i);
        srst_i = 1'b0;
        osc_stable_i = 1'b1;
        repeat (20) @(negedge clk_i);
        `CHK("held by pin", 1'b1, core_reset_o)
        ext_pin = 1'b1;
        check_reset(3'h1, 5'h00, 1'b1);
        $display("test power-on done");
        // each source alone, then random mixes resolved by priority
        en_wdata_i = 5'h1F;
        pulse(en_write_i);
        pulse(mask_clear_i);
        for (int i = 0; i < 16; i++) begin
            r = (i < 5) ? (1 << i) : $urandom_range(1, 31);
            for (int b = 4; b >= 0; b--) if (r[b]) idx = b;
            irq_req_i = 5'(r);
            take(vec_of(idx));
            irq_req_i = 5'h00;
            do_rti(1'b0);
        end
        $display("test sources done");
        // refused while masked or disabled, taken once both allow it
        pulse(mask_set_i);
        irq_req_i = 5'h04;
        pulse(instr_done_i);
        repeat (3) @(negedge clk_i);
        `CHK("masked push", 1'b0, push_req_o)
        en_wdata_i = 5'h1B;
        pulse(en_write_i);
        pulse(mask_clear_i);
        pulse(instr_done_i);
        repeat (3) @(negedge clk_i);
        `CHK("disabled push", 1'b0, push_req_o)
        en_wdata_i = 5'h1F;
        pulse(en_write_i);
        take(14'h3FF8);
        irq_req_i = 5'h00;
        do_rti(1'b1);
        // software interrupt ignores the mask; pending hardware goes first
        pulse(swi_fetch_i);
        take(14'h3FFC);
        do_rti(1'b0);
        irq_req_i = 5'h08;
        pulse(swi_fetch_i);
        take(14'h3FF6);
        irq_req_i = 5'h00;
        take(14'h3FFC);
        do_rti(1'b0);
        // alternate request carries no snapshot, so it outranks pending hardware
        irq_req_i = 5'h08;
        pulse(swi_exec);
        take(14'h3FFC);
        irq_req_i = 5'h00;
        do_rti(1'b0);
        $display("test masking and software done");
        // short pin pulse refused, long one resets and clears enables
        ext_pin = 1'b0;
        repeat (2) @(negedge clk_i);
        ext_pin = 1'b1;
        repeat (4) @(negedge clk_i);
        `CHK("short pin", 1'b0, core_reset_o)
        ext_pin = 1'b0;
        repeat (5) @(negedge clk_i);
        `CHK("pin reset", 1'b1, core_reset_o)
        ext_pin = 1'b1;
        check_reset(3'h1, 5'h00, 1'b1);
        $display("test pin done");
        // fetch range edges; illegal resets keep the enables
        exp_en = 5'h15;
        en_wdata_i = exp_en;
        pulse(en_write_i);
        foreach (good_q[k]) begin
            fetch_addr_i = good_q[k];
            pulse(fetch_valid_i);
            `CHK("legal fetch", 1'b0, core_reset_o)
            @(negedge clk_i);
        end
        foreach (bad_q[k]) begin
            fetch_addr_i = bad_q[k];
            pulse(fetch_valid_i);
            `CHK("illegal fetch", 1'b1, core_reset_o)
            check_reset(3'h3, exp_en, 1'b1);
        end
        // watchdog keeps the mode even with the strap changed
        mode_sel_i = 1'b0;
        pulse(watchdog_timeout_i);
        `CHK("watchdog", 1'b1, core_reset_o)
        check_reset(3'h4, exp_en, 1'b1);
        $display("test illegal and watchdog done");
        // low supply drives the pin low and holds reset
        low_voltage_i = 1'b1;
        @(negedge clk_i);
        `CHK("pin drive", 2'h2, {reset_pin_oe_o, reset_pin_o})
        repeat (3) @(negedge clk_i);
        `CHK("lv reset", 1'b1, core_reset_o)
        low_voltage_i = 1'b0;
        @(negedge clk_i);
        `CHK("pin release", 1'b0, reset_pin_oe_o)
        check_reset(3'h2, 5'h00, 1'b0);
        $display("test low voltage done");
        // mid-run reset with the pin high: power-on cause, mode resampled
        mode_sel_i = 1'b1;
        srst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        srst_i = 1'b0;
        @(negedge clk_i);
        `CHK("por wait", 1'b1, core_reset_o)
        check_reset(3'h0, 5'h00, 1'b1);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule : reset_and_interrupt_sequencer_tb

`default_nettype wire
